// ---- core/cbram_top.sv ----
// configurable dual-port block ram with bank select and output options
`include "cbram_defines.svh"
module cbram_top
  import cbram_pkg::*;
#(
  parameter int DATA_W = `CBRAM_DEF_DATA_W,
  parameter int ADDR_W = `CBRAM_DEF_ADDR_W,
  parameter cbram_cfg_t PORT_CONFIG = true_dual_port,
  parameter cbram_pipe_t OUTPUT_PIPELINE = output_unregistered,
  parameter cbram_rst_t RESET_STYLE = clocked_reset,
  parameter logic [`CBRAM_BANK_W-1:0] PORT_A_MATCH = `CBRAM_DEF_MATCH,
  parameter logic [`CBRAM_BANK_W-1:0] PORT_B_MATCH = `CBRAM_DEF_MATCH,
  parameter logic [`CBRAM_BANK_W-1:0] WRITE_MATCH = `CBRAM_DEF_MATCH,
  parameter logic [`CBRAM_BANK_W-1:0] READ_MATCH = `CBRAM_DEF_MATCH,
  parameter cbram_wmode_t PORT_A_BEHAVIOUR = write_keeps_output,
  parameter cbram_wmode_t PORT_B_BEHAVIOUR = write_keeps_output,
  parameter bit CHIP_RESET_ENABLE = 1'b1
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic memReset,
  input wire logic chipSetReset_b,
  // port a (write port in pseudo dual configuration)
  input wire logic portAEnable,
  input wire logic [`CBRAM_BANK_W-1:0] portABank,
  input wire logic [ADDR_W-1:0] portAAddr,
  input wire logic portAWrite,
  input wire logic [DATA_W-1:0] portAWriteData,
  output logic [DATA_W-1:0] portAReadData,
  // port b (read port in pseudo dual configuration)
  input wire logic portBEnable,
  input wire logic [`CBRAM_BANK_W-1:0] portBBank,
  input wire logic [ADDR_W-1:0] portBAddr,
  input wire logic portBWrite,
  input wire logic [DATA_W-1:0] portBWriteData,
  output logic [DATA_W-1:0] portBReadData
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam bit PSEUDO = (PORT_CONFIG == pseudo_dual_port);
  localparam bit A_OLD = (PORT_A_BEHAVIOUR == old_data_on_write);
  localparam bit B_OLD = (PORT_B_BEHAVIOUR == old_data_on_write);
  localparam bit OLD_WIDTH_OK = (DATA_W == `CBRAM_OLD_W_SMALL) ||
                                (DATA_W == `CBRAM_OLD_W_MID) ||
                                (DATA_W == `CBRAM_OLD_W_LARGE);

  // refuse settings the logic cannot serve
  generate
    if (ADDR_W < `CBRAM_MIN_ADDR_W || DATA_W < 1) begin : gBadSize
      $error("cbram_top: address and data widths must be positive");
    end
    if ((A_OLD || B_OLD) && !OLD_WIDTH_OK) begin : gBadOld
      $error("cbram_top: old-data behaviour needs width 9, 18 or 36");
    end
    if (PSEUDO && (A_OLD || B_OLD)) begin : gBadPseudo
      $error("cbram_top: old-data behaviour needs true dual port");
    end
  endgenerate

  logic [DATA_W-1:0] memArray [DEPTH];

  // effective bank match per port, by configuration
  wire [`CBRAM_BANK_W-1:0] matchA = PSEUDO ? WRITE_MATCH
                                           : PORT_A_MATCH;
  wire [`CBRAM_BANK_W-1:0] matchB = PSEUDO ? READ_MATCH
                                           : PORT_B_MATCH;

  // bank decode: select bits must equal the port's match value to enable access
  wire bankHitA = (portABank == matchA);
  wire bankHitB = (portBBank == matchB);
  wire accessA = portAEnable && bankHitA;
  wire accessB = portBEnable && bankHitB;

  // pseudo dual fixes port a to writing, port b to reading
  wire writeA = accessA && (portAWrite || PSEUDO);
  wire writeB = accessB && portBWrite && !PSEUDO;
  wire readAccessA = accessA && !PSEUDO;

  // stored contents before this cycle's write
  wire [DATA_W-1:0] storedA = memArray[portAAddr];
  wire [DATA_W-1:0] storedB = memArray[portBAddr];

  // core reset decode for the two styles
  wire chipReset = CHIP_RESET_ENABLE && !chipSetReset_b;
  wire unclockedReset = (RESET_STYLE == unclocked_reset) && memReset;
  wire clockedReset = (RESET_STYLE == clocked_reset) && memReset;
  wire outRst_b = rst_b && !unclockedReset && !chipReset;

  // array write; port b lands last if both hit one address
  always_ff @(posedge clk) begin
    if (writeA) begin
      memArray[portAAddr] <= portAWriteData;
    end
    if (writeB) begin
      memArray[portBAddr] <= portBWriteData;
    end
  end

  // port a output path with its own write behaviour
  cbram_port_out #(
    .DATA_W(DATA_W),
    .WRITE_BEHAVIOUR(PORT_A_BEHAVIOUR),
    .OUTPUT_PIPELINE(OUTPUT_PIPELINE)
  ) uPortAOut (
    .clk(clk),
    .outRst_b(outRst_b),
    .syncClear(clockedReset),
    .accessEn(readAccessA),
    .writeEn(writeA),
    .writeData(portAWriteData),
    .storedData(storedA),
    .readData(portAReadData)
  );

  // port b output path with its own write behaviour
  cbram_port_out #(
    .DATA_W(DATA_W),
    .WRITE_BEHAVIOUR(PORT_B_BEHAVIOUR),
    .OUTPUT_PIPELINE(OUTPUT_PIPELINE)
  ) uPortBOut (
    .clk(clk),
    .outRst_b(outRst_b),
    .syncClear(clockedReset),
    .accessEn(accessB),
    .writeEn(writeB),
    .writeData(portBWriteData),
    .storedData(storedB),
    .readData(portBReadData)
  );

endmodule : cbram_top

// ---- inc/cbram_defines.svh ----
// shared constants of the configurable block ram
`ifndef CBRAM_DEFINES_SVH
`define CBRAM_DEFINES_SVH
`define CBRAM_BANK_W 3
`define CBRAM_DEF_DATA_W 9
`define CBRAM_DEF_ADDR_W 10
`define CBRAM_MIN_ADDR_W 1
`define CBRAM_OLD_W_SMALL 9
`define CBRAM_OLD_W_MID 18
`define CBRAM_OLD_W_LARGE 36
`define CBRAM_DEF_MATCH 3'h0
`define CBRAM_DOUT_RST 1'b0
`endif

// ---- inc/cbram_pkg.sv ----
// option types of the configurable block ram
package cbram_pkg;
  typedef enum logic {
    output_unregistered = 1'b0,
    output_registered = 1'b1
  } cbram_pipe_t;
  typedef enum logic {
    clocked_reset = 1'b0,
    unclocked_reset = 1'b1
  } cbram_rst_t;
  typedef enum logic [1:0] {
    write_keeps_output = 2'b00,
    write_data_to_output = 2'b01,
    old_data_on_write = 2'b10
  } cbram_wmode_t;
  typedef enum logic {
    true_dual_port = 1'b0,
    pseudo_dual_port = 1'b1
  } cbram_cfg_t;
endpackage : cbram_pkg

// ---- core/cbram_port_out.sv ----
// read-data output path of one ram port
`include "cbram_defines.svh"
module cbram_port_out
  import cbram_pkg::*;
#(
  parameter int DATA_W = `CBRAM_DEF_DATA_W,
  parameter cbram_wmode_t WRITE_BEHAVIOUR = write_keeps_output,
  parameter cbram_pipe_t OUTPUT_PIPELINE = output_unregistered
) (
  // clock and resets
  input wire logic clk,
  input wire logic outRst_b,
  input wire logic syncClear,
  // access of this port
  input wire logic accessEn,
  input wire logic writeEn,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic [DATA_W-1:0] storedData,
  // result
  output logic [DATA_W-1:0] readData
);

  logic [DATA_W-1:0] latchData;
  logic [DATA_W-1:0] pipeData;
  logic [DATA_W-1:0] next_latchData;

  // value taken by the output latch this cycle
  always_comb begin
    next_latchData = latchData;
    if (accessEn && !writeEn) begin
      next_latchData = storedData;
    end else if (accessEn && writeEn) begin
      case (WRITE_BEHAVIOUR)
        write_keeps_output: next_latchData = latchData;
        write_data_to_output: next_latchData = writeData;
        old_data_on_write: next_latchData = storedData;
        default: next_latchData = latchData;
      endcase
    end
  end

  // output latch, cleared by core reset in either style
  always_ff @(posedge clk or negedge outRst_b) begin
    if (!outRst_b) begin
      latchData <= {DATA_W{`CBRAM_DOUT_RST}};
    end else if (syncClear) begin
      latchData <= {DATA_W{`CBRAM_DOUT_RST}};
    end else begin
      latchData <= next_latchData;
    end
  end

  // optional pipeline stage, one extra cycle of latency
  always_ff @(posedge clk or negedge outRst_b) begin
    if (!outRst_b) begin
      pipeData <= {DATA_W{`CBRAM_DOUT_RST}};
    end else if (syncClear) begin
      pipeData <= {DATA_W{`CBRAM_DOUT_RST}};
    end else begin
      pipeData <= latchData;
    end
  end

  // fixed selection of the driving flop
  assign readData = (OUTPUT_PIPELINE == output_registered) ?
                    pipeData : latchData;

endmodule : cbram_port_out

// ---- sim/cbram_user_model.sv ----
// user logic model: collision guard in front of the ram ports
module cbram_user_model (
  // requests and guarded outputs
  input wire logic aEn, aWr, bEn, bWr,
  input wire logic [3:0] aAd, bAd,
  output logic bEnGated,
  output logic collide
);
  timeunit 1ns;
  timeprecision 1ns;
  // flag same word on both ports with a write, block a double write
  assign collide = aEn && bEn && aAd == bAd && (aWr || bWr);
  assign bEnGated = bEn && !(collide && aWr && bWr);
endmodule : cbram_user_model

// ---- sim/cbram_top_monitor.sv ----
// port assertions of the configurable block ram
module cbram_top_monitor #(
  parameter int DATA_W = 9,
  parameter int ADDR_W = 10,
  parameter logic [2:0] PORT_A_MATCH = 3'h0,
  parameter logic [2:0] PORT_B_MATCH = 3'h0
) (
  // clock, resets, requests and read data
  input wire logic clk, rst_b, memReset, chipSetReset_b,
  input wire logic portAEnable, portAWrite, portBEnable, portBWrite,
  input wire logic [2:0] portABank, portBBank,
  input wire logic [ADDR_W-1:0] portAAddr, portBAddr,
  input wire logic [DATA_W-1:0] portAWriteData, portBWriteData,
  input wire logic [DATA_W-1:0] portAReadData, portBReadData
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !chipSetReset_b);
  // accepted accesses with the core reset low
  wire logic accA = portAEnable && portABank == PORT_A_MATCH && !memReset;
  wire logic accB = portBEnable && portBBank == PORT_B_MATCH && !memReset;
  sequence s_a_wr; accA && portAWrite && !portBEnable; endsequence
  sequence s_b_wr; accB && portBWrite && !portAEnable; endsequence
  property p_a_hold; !accA && !memReset |=> $stable(portAReadData);
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("A moved");
  property p_b_hold; !accB && !memReset |=> $stable(portBReadData);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("B moved");
  property p_a_thru; accA && portAWrite |=>
    portAReadData == $past(portAWriteData); endproperty
  a_a_thru: assert property (p_a_thru) else $error("A thru");
  property p_a_back; s_a_wr ##1 (accA && !portAWrite && !portBEnable &&
    portAAddr == $past(portAAddr)) |=>
    portAReadData == $past(portAWriteData, 2); endproperty
  a_a_back: assert property (p_a_back) else $error("A back");
  property p_b_old; s_b_wr ##1 s_b_wr ##0 portBAddr == $past(portBAddr)
    |=> portBReadData == $past(portBWriteData, 2); endproperty
  a_b_old: assert property (p_b_old) else $error("B old");
  property p_clr; memReset |=> portAReadData == '0 && portBReadData == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_early; $rose(memReset) && !$past(portAEnable) &&
    !$past(portBEnable) |-> $stable(portAReadData) &&
    $stable(portBReadData); endproperty
  a_early: assert property (p_early) else $error("early clear");
  property p_chip; @(posedge clk) disable iff (!rst_b) !chipSetReset_b
    |-> portAReadData == '0 && portBReadData == '0; endproperty
  a_chip: assert property (p_chip) else $error("chip reset");
endmodule : cbram_top_monitor
bind cbram_top cbram_top_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W),
  .PORT_A_MATCH(PORT_A_MATCH), .PORT_B_MATCH(PORT_B_MATCH)) mon_u (
  .clk(clk), .rst_b(rst_b), .memReset(memReset),
  .chipSetReset_b(chipSetReset_b), .portAEnable(portAEnable),
  .portAWrite(portAWrite), .portBEnable(portBEnable),
  .portBWrite(portBWrite), .portABank(portABank), .portBBank(portBBank),
  .portAAddr(portAAddr), .portBAddr(portBAddr),
  .portAWriteData(portAWriteData), .portBWriteData(portBWriteData),
  .portAReadData(portAReadData), .portBReadData(portBReadData));

// ---- sim/cbram_top_tb.sv ----
// self-checking bench of the configurable block ram
module cbram_top_tb import cbram_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, memReset = 1'b0, chipSetReset_b = 1'b1;
  logic aEn = 1'b0, aWr = 1'b0, bEn = 1'b0, bWr = 1'b0, vA, vB;
  logic [2:0] aBk = 3'h0, bBk = 3'h0;
  logic [3:0] aAd = 4'h0, bAd = 4'h0;
  logic [8:0] aD = 9'h000, bD = 9'h000, eA, eB, mem [16];
  logic [15:0] r = 16'h0021;
  wire logic bEnG, coll;
  wire logic [8:0] qA, qB;
  int n_errors = 0, checks_done = 0;
  cbram_user_model um_u (.aEn(aEn), .aWr(aWr), .bEn(bEn), .bWr(bWr),
    .aAd(aAd), .bAd(bAd), .bEnGated(bEnG), .collide(coll));
  cbram_top #(.ADDR_W(4), .PORT_A_MATCH(3'h5), .PORT_B_MATCH(3'h2),
    .PORT_A_BEHAVIOUR(write_data_to_output),
    .PORT_B_BEHAVIOUR(old_data_on_write)) dut_u (.clk(clk), .rst_b(rst_b),
    .memReset(memReset), .chipSetReset_b(chipSetReset_b),
    .portAEnable(aEn), .portABank(aBk), .portAAddr(aAd), .portAWrite(aWr),
    .portAWriteData(aD), .portAReadData(qA), .portBEnable(bEnG),
    .portBBank(bBk), .portBAddr(bAd), .portBWrite(bWr),
    .portBWriteData(bD), .portBReadData(qB));
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // drive one cycle, check the last one, predict this one
  task automatic go(input logic [17:0] a, b, input logic m);
    @(posedge clk);
    {aEn, aWr, aBk, aAd, aD} <= a;
    {bEn, bWr, bBk, bAd, bD} <= b;
    memReset <= m;
    #1;
    if (vA) cmp(qA, eA);
    if (vB) cmp(qB, eB);
    if (memReset) {vA, vB, eA, eB} = 20'h3_0000;
    else begin
      if (aEn && aBk == 3'h5) {vA, eA} = {!coll || aWr, aWr ? aD : mem[aAd]};
      if (bEnG && bBk == 3'h2) {vB, eB} = {!coll, mem[bAd]};
      if (aEn && aBk == 3'h5 && aWr) mem[aAd] = aD;
      if (bEnG && bBk == 3'h2 && bWr) mem[bAd] = bD;
    end
  endtask : go
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // fill, corner cases, bank sweep, random traffic, resets
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    {vA, vB, eA, eB} = 20'h3_0000;
    for (int i = 0; i < 16; i++)
      go({5'h1D, 4'(i), 9'(i * 37)}, 0, 0);
    go({5'h1D, 4'h7, 9'h1AB}, 0, 0);
    go({5'h15, 4'h7, 9'h000}, 0, 0);
    go(0, {5'h1A, 4'h3, 9'h0F0}, 0);
    go(0, {5'h1A, 4'h3, 9'h10F}, 0);
    for (int k = 0; k < 8; k++)
      go({2'h3, 3'(k), 4'h9, 9'(k + 9)},
        {2'h3, 3'(k), 4'hA, 9'h1FF}, 0);
    for (int i = 0; i < 400; i++) begin
      r = lfsr(r);
      go({1'b1, r[0], r[1] ? 3'h5 : r[4:2], r[8:5], r[15:7]},
        {r[9], r[10], r[11] ? 3'h2 : r[14:12], r[3:0], r[14:6]}, 0);
    end
    go({5'h1D, 4'h7, 9'h155}, 0, 0);
    go({5'h15, 4'h7, 9'h0}, {5'h12, 4'h7, 9'h0}, 0);
    go(0, 0, 0);
    go(0, 0, 1);
    go(0, 0, 0);
    // outputs nonzero again, so the chip-wide clear is visible
    go({5'h15, 4'h7, 9'h0}, {5'h12, 4'h7, 9'h0}, 0);
    go(0, 0, 0);
    @(posedge clk);
    chipSetReset_b <= 1'b0;
    #1;
    cmp(qA, 9'h000);
    cmp(qB, 9'h000);
    @(posedge clk);
    chipSetReset_b <= 1'b1;
    {vA, vB, eA, eB} = 20'h3_0000; // outputs stay cleared
    go(0, 0, 0);
    report_and_stop();
  end
endmodule : cbram_top_tb
